// ==== src/diag_counters_pkg.sv ====
// types shared by the diagnostic counters and their surroundings
// assumes currents are fundamental magnitudes in amperes
package diag_counters_pkg;

  // three phase fundamental magnitudes
  typedef struct packed {
    logic [15:0] ph3;
    logic [15:0] ph2;
    logic [15:0] ph1;
  } phase_current_t;

  // breaking current totals, band 0 lowest
  typedef struct packed {
    logic [4:0][15:0] band;
    logic [15:0]      total;
    logic [15:0]      ops;
  } breaker_totals_t;

  // image kept in non-volatile storage
  typedef struct packed {
    logic [15:0]     runHours;
    logic [15:0]     thermal;
    logic [15:0]     startDur;
    logic [15:0]     startPeak;
    breaker_totals_t brk;
  } nv_image_t;

endpackage

// ==== src/diag_counters_regs.svh ====
// constants of the machine and switchgear diagnostic counters
// assumes a 25 MHz core clock and currents scaled in amperes
//
// What this block does
// RQ1 - count running hours while any phase current exceeds a tenth of base_current
// RQ2 - request a non-volatile save of the hours every four elapsed hours
// RQ3 - an external preset value replaces the running-hours count
// RQ4 - on thermal trip, save thermal capacity used plus ten percent
// RQ5 - clear the saved thermal value once start-inhibit delay reaches zero
// RQ6 - after power returns, seed the thermal calculation from the saved value
// RQ7 - report thermal capacity used in whole percent of rated capacity
// RQ8 - remaining time before trip in minutes, clamped to 999, refreshed each second
// RQ9 - waiting time after trip in minutes, clamped to 999, refreshed each second
// RQ10 - time the period while any phase exceeds 1.2 times base_current
// RQ11 - capture the largest phase current seen during that period
// RQ12 - save starting duration and peak current to non-volatile storage
// RQ13 - starts counters 0 to 60, cleared only after accepted password
// RQ14 - report start-inhibit minutes, 0 to 360, while starting is inhibited
// RQ15 - accumulate squared breaking current in five bands of rated current
// RQ16 - keep a grand total in kA squared up to 65535 and an operation count
// RQ17 - each trip_output_relay command counts one operation and accumulates current
// RQ18 - breaking current uses the fundamental-frequency current magnitudes
// RQ19 - save band totals, grand total and operation count to non-volatile storage
// RQ20 - breaker totals and operation count accept external preset values
// RQ21 - every 16-bit counter saturates instead of wrapping
`ifndef DIAG_COUNTERS_REGS_SVH
`define DIAG_COUNTERS_REGS_SVH

// ----------------------------------------------------------------
// time base
// ----------------------------------------------------------------
`define CLK_KHZ      25000
`define SECOND_MS    1000
`define CENTI_MS     10
`define HOUR_SEC     12'he10
`define NV_PERIOD_H  3'h4

// ----------------------------------------------------------------
// thresholds, ratios as divider over multiplier
// ----------------------------------------------------------------
`define RUN_MUL      20'h0000a
`define RUN_DEN      20'h00001
`define START_MUL    20'h00005
`define START_DEN    20'h00006
`define BAND_2       24'h000002
`define BAND_5       24'h000005
`define BAND_10      24'h00000a
`define BAND_40      24'h000028
`define KA2_DIV      32'h000f4240

// ----------------------------------------------------------------
// limits and increments
// ----------------------------------------------------------------
`define THERM_BUMP   16'h000a
`define MIN_MAX      16'h03e7
`define INHIB_MAX    16'h0168
`define STARTS_MAX   8'h3c
`define DUR_MAX      16'h7530
`define SAT16        16'hffff

`endif

// ==== src/machine_switchgear_diag_counters.sv ====
// diagnostic counters and captured values of a protection relay
// assumes protection results arrive on core_clk and the storage
// controller outside takes the save pulses and performs restore
`timescale 1ns/100ps
`include "diag_counters_regs.svh"

module machine_switchgear_diag_counters #(
  parameter int SEC_CYCLES   = `SECOND_MS * `CLK_KHZ,
  parameter int CENTI_CYCLES = `CENTI_MS * `CLK_KHZ
) (
  // clock and reset
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  // settings and currents
  input  wire logic [15:0]                     baseCurrent,
  input  wire logic [15:0]                     ratedCurrent,
  input  wire diag_counters_pkg::phase_current_t phaseCurrent,
  // thermal and starts protection results
  input  wire logic [15:0]                     thermalPct,
  input  wire logic                            thermalTrip,
  input  wire logic [15:0]                     remainMinIn,
  input  wire logic [15:0]                     waitMinIn,
  input  wire logic                            startInhibited,
  input  wire logic [15:0]                     inhibitMinIn,
  input  wire logic [7:0]                      startsLeftIn,
  input  wire logic                            startsClearReq,
  input  wire logic                            passwordOk,
  // trip_output_relay command
  input  wire logic                            tripOutputRelay,
  // presets and restore
  input  wire logic                            presetHoursLoad,
  input  wire logic [15:0]                     presetHours,
  input  wire logic                            presetBrkLoad,
  input  wire diag_counters_pkg::breaker_totals_t presetBrk,
  input  wire logic                            nvRestore,
  input  wire diag_counters_pkg::nv_image_t    nvRestoreImage,
  // readouts
  output logic [15:0]                          runHours_q,
  output logic [15:0]                          thermalUsed_q,
  output logic [15:0]                          thermalSaved_q,
  output logic [15:0]                          remainMin_q,
  output logic [15:0]                          waitMin_q,
  output logic [15:0]                          inhibitMin_q,
  output logic [7:0]                           startsLeft_q,
  output logic [15:0]                          startDur_q,
  output logic [15:0]                          startPeak_q,
  output diag_counters_pkg::breaker_totals_t   brk_q,
  // commands to neighbours
  output logic                                 thermalSeedLoad_q,
  output logic                                 startsClear_q,
  // save requests to non-volatile storage
  output logic                                 nvSaveHours_q,
  output logic                                 nvSaveThermal_q,
  output logic                                 nvSaveStart_q,
  output logic                                 nvSaveBreaker_q
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // saturating add, no wrap on any counter
  function automatic logic [15:0] sat16add(input logic [15:0] a, input logic [31:0] b);
    logic [32:0] s;
    s = 33'(a) + 33'(b);
    return (s > 33'(`SAT16)) ? `SAT16 : s[15:0];
  endfunction

  function automatic logic [15:0] clampTo(input logic [15:0] v, input logic [15:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // i * mul > ib * den, ratio compare without division
  function automatic logic above(input logic [15:0] i, input logic [15:0] ib,
                                 input logic [19:0] mul, input logic [19:0] den);
    return (20'(i) * mul) > (20'(ib) * den);
  endfunction

  // ----------------------------------------------------------------
  // decoding
  // ----------------------------------------------------------------
  logic [15:0] ph1;
  logic [15:0] ph2;
  logic [15:0] ph3;
  logic [15:0] max12;
  logic [15:0] maxPhase;
  logic        running;
  logic        overStart;
  logic        startsAccept;

  assign ph1 = phaseCurrent.ph1;
  assign ph2 = phaseCurrent.ph2;
  assign ph3 = phaseCurrent.ph3;
  assign max12 = (ph1 > ph2) ? ph1 : ph2;
  assign maxPhase = (max12 > ph3) ? max12 : ph3;
  // any phase above a tenth of base_current
  assign running = above(ph1, baseCurrent, `RUN_MUL, `RUN_DEN) |
                   above(ph2, baseCurrent, `RUN_MUL, `RUN_DEN) |
                   above(ph3, baseCurrent, `RUN_MUL, `RUN_DEN); // RQ1
  // any phase above 1.2 base_current
  assign overStart = above(ph1, baseCurrent, `START_MUL, `START_DEN) |
                     above(ph2, baseCurrent, `START_MUL, `START_DEN) |
                     above(ph3, baseCurrent, `START_MUL, `START_DEN); // RQ10
  assign startsAccept = startsClearReq & passwordOk; // RQ13

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [31:0] secCnt_q;
  logic [31:0] centiCnt_q;
  logic        secTick;
  logic        centiTick;

  assign secTick = (secCnt_q == 32'(SEC_CYCLES - 1));
  assign centiTick = (centiCnt_q == 32'(CENTI_CYCLES - 1));

  // free-running second and 10 ms strobes
  always_ff @(posedge core_clk) begin
    if (reset || secTick) begin
      secCnt_q <= 32'h0;
    end else begin
      secCnt_q <= secCnt_q + 32'h1;
    end
    if (reset || centiTick) begin
      centiCnt_q <= 32'h0;
    end else begin
      centiCnt_q <= centiCnt_q + 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // running hours and periodic save
  // ----------------------------------------------------------------
  logic [11:0] runSec_q;
  logic [11:0] nvSec_q;
  logic [2:0]  nvHour_q;
  logic        runHourDone;
  logic        nvHourDone;

  assign runHourDone = secTick & running & (runSec_q == `HOUR_SEC - 12'h1);
  assign nvHourDone = secTick & (nvSec_q == `HOUR_SEC - 12'h1);

  // seconds within the hour only advance while the machine runs
  always_ff @(posedge core_clk) begin
    if (reset) begin
      runSec_q   <= 12'h0;
      runHours_q <= 16'h0;
    end else begin
      if (runHourDone) begin
        runSec_q <= 12'h0;
      end else if (secTick && running) begin
        runSec_q <= runSec_q + 12'h1; // RQ1
      end
      if (nvRestore) begin
        runHours_q <= nvRestoreImage.runHours;
      end else if (presetHoursLoad) begin
        runHours_q <= presetHours; // RQ3
      end else if (runHourDone) begin
        runHours_q <= sat16add(runHours_q, 32'h1); // RQ21
      end
    end
  end

  // elapsed time counts regardless of load
  always_ff @(posedge core_clk) begin
    if (reset) begin
      nvSec_q       <= 12'h0;
      nvHour_q      <= 3'h0;
      nvSaveHours_q <= 1'b0;
    end else begin
      nvSaveHours_q <= 1'b0;
      if (nvHourDone) begin
        nvSec_q <= 12'h0;
        if (nvHour_q == `NV_PERIOD_H - 3'h1) begin
          nvHour_q      <= 3'h0;
          nvSaveHours_q <= 1'b1; // RQ2
        end else begin
          nvHour_q <= nvHour_q + 3'h1;
        end
      end else if (secTick) begin
        nvSec_q <= nvSec_q + 12'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // thermal capacity save, clear and restore
  // ----------------------------------------------------------------
  // a trip in the same cycle as the clear condition wins
  always_ff @(posedge core_clk) begin
    if (reset) begin
      thermalSaved_q    <= 16'h0;
      thermalSeedLoad_q <= 1'b0;
      nvSaveThermal_q   <= 1'b0;
      thermalUsed_q     <= 16'h0;
    end else begin
      thermalSeedLoad_q <= nvRestore; // RQ6
      nvSaveThermal_q   <= 1'b0;
      if (nvRestore) begin
        thermalSaved_q <= nvRestoreImage.thermal; // RQ6
      end else if (thermalTrip) begin
        thermalSaved_q  <= sat16add(thermalPct, 32'(`THERM_BUMP)); // RQ4
        nvSaveThermal_q <= 1'b1;
      end else if (inhibitMinIn == 16'h0 && thermalSaved_q != 16'h0) begin
        thermalSaved_q  <= 16'h0; // RQ5
        nvSaveThermal_q <= 1'b1;
      end
      if (secTick) begin
        thermalUsed_q <= thermalPct; // RQ7
      end
    end
  end

  // ----------------------------------------------------------------
  // minute readouts and number of starts
  // ----------------------------------------------------------------
  // refreshed once a second so the display does not flicker
  always_ff @(posedge core_clk) begin
    if (reset) begin
      remainMin_q   <= 16'h0;
      waitMin_q     <= 16'h0;
      inhibitMin_q  <= 16'h0;
      startsLeft_q  <= 8'h0;
      startsClear_q <= 1'b0;
    end else begin
      startsClear_q <= startsAccept; // RQ13
      if (secTick) begin
        remainMin_q  <= clampTo(remainMinIn, `MIN_MAX); // RQ8
        waitMin_q    <= clampTo(waitMinIn, `MIN_MAX); // RQ9
        inhibitMin_q <= startInhibited ? clampTo(inhibitMinIn, `INHIB_MAX) : 16'h0; // RQ14
      end
      if (startsAccept) begin
        startsLeft_q <= 8'h0; // RQ13
      end else if (secTick) begin
        startsLeft_q <= (startsLeftIn > `STARTS_MAX) ? `STARTS_MAX : startsLeftIn;
      end
    end
  end

  // ----------------------------------------------------------------
  // starting or overload period
  // ----------------------------------------------------------------
  logic overActive_q;

  // duration in 10 ms steps, held at 300 s
  always_ff @(posedge core_clk) begin
    if (reset) begin
      overActive_q  <= 1'b0;
      startDur_q    <= 16'h0;
      startPeak_q   <= 16'h0;
      nvSaveStart_q <= 1'b0;
    end else begin
      overActive_q  <= overStart;
      nvSaveStart_q <= overActive_q & ~overStart; // RQ12
      if (nvRestore) begin
        startDur_q  <= nvRestoreImage.startDur; // RQ12
        startPeak_q <= nvRestoreImage.startPeak;
      end else if (overStart && !overActive_q) begin
        startDur_q  <= 16'h0; // RQ10
        startPeak_q <= maxPhase; // RQ11
      end else if (overStart) begin
        if (centiTick && startDur_q != `DUR_MAX) begin
          startDur_q <= startDur_q + 16'h1; // RQ10
        end
        if (maxPhase > startPeak_q) begin
          startPeak_q <= maxPhase; // RQ11
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // cumulative breaking current
  // ----------------------------------------------------------------
  logic        tripLast_q;
  logic        tripRise;
  logic [31:0] breakKa2;
  logic [2:0]  bandSel;
  logic [23:0] iWide;

  // phase inputs are already fundamental magnitudes
  assign iWide = 24'(maxPhase); // RQ18
  assign tripRise = tripOutputRelay & ~tripLast_q; // RQ17
  assign breakKa2 = (32'(maxPhase) * 32'(maxPhase)) / `KA2_DIV;
  assign bandSel = (iWide < 24'(ratedCurrent) * `BAND_2)  ? 3'h0 :
                   (iWide < 24'(ratedCurrent) * `BAND_5)  ? 3'h1 :
                   (iWide < 24'(ratedCurrent) * `BAND_10) ? 3'h2 :
                   (iWide < 24'(ratedCurrent) * `BAND_40) ? 3'h3 : 3'h4; // RQ15

  // one accumulation per rising trip command, never per cycle held
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tripLast_q      <= 1'b0;
      brk_q           <= '0;
      nvSaveBreaker_q <= 1'b0;
    end else begin
      tripLast_q      <= tripOutputRelay;
      nvSaveBreaker_q <= tripRise; // RQ19
      if (nvRestore) begin
        brk_q <= nvRestoreImage.brk; // RQ19
      end else if (presetBrkLoad) begin
        brk_q <= presetBrk; // RQ20
      end else if (tripRise) begin
        brk_q.ops   <= sat16add(brk_q.ops, 32'h1); // RQ17
        brk_q.total <= sat16add(brk_q.total, breakKa2); // RQ16
        for (int b = 0; b < 5; b++) begin
          if (bandSel == 3'(b)) begin
            brk_q.band[b] <= sat16add(brk_q.band[b], breakKa2); // RQ15
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  a_hours_saturate: assert property ( // RQ21
    runHours_q == `SAT16 && !nvRestore && !presetHoursLoad |=> runHours_q == `SAT16)
    else $error("running hours wrapped");

  a_hours_preset: assert property ( // RQ3
    presetHoursLoad && !nvRestore |=> runHours_q == $past(presetHours))
    else $error("hours preset not taken");

  a_hours_idle: assert property ( // RQ1
    !running && !nvRestore && !presetHoursLoad |=> runHours_q == $past(runHours_q))
    else $error("hours counted while idle");

  a_thermal_save: assert property ( // RQ4
    thermalTrip && !nvRestore
      |=> thermalSaved_q == sat16add($past(thermalPct), 32'(`THERM_BUMP)) && nvSaveThermal_q)
    else $error("thermal save value wrong");

  a_thermal_clear: assert property ( // RQ5
    inhibitMinIn == 16'h0 && !thermalTrip && !nvRestore |=> thermalSaved_q == 16'h0)
    else $error("thermal value not cleared");

  a_minute_clamp: assert property ( // RQ8
    remainMin_q <= `MIN_MAX && waitMin_q <= `MIN_MAX && inhibitMin_q <= `INHIB_MAX)
    else $error("minute readout out of range");

  a_starts_clear: assert property ( // RQ13
    startsAccept |=> startsLeft_q == 8'h0 && startsClear_q)
    else $error("starts clear not honoured");

  a_starts_guard: assert property ( // RQ13
    startsClearReq && !passwordOk |=> !startsClear_q)
    else $error("starts cleared without password");

  a_peak_track: assert property ( // RQ11
    overStart && !nvRestore |=> startPeak_q >= $past(maxPhase))
    else $error("peak current missed");

  a_op_count: assert property ( // RQ17
    tripRise && !nvRestore && !presetBrkLoad && brk_q.ops != `SAT16
      |=> brk_q.ops == $past(brk_q.ops) + 16'h1 ##1 brk_q.ops == $past(brk_q.ops))
    else $error("operation count wrong");

endmodule // machine_switchgear_diag_counters

// ==== tb/machine_switchgear_diag_counters_test.sv ====
// self-checking bench for the machine and switchgear diagnostic counters
// assumes short time bases: 20 clocks a second tick, 4 clocks a 10 ms tick
`timescale 1ns/100ps

module machine_switchgear_diag_counters_test;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct {
    logic [15:0] cur;
    int          band;
  } row_t;

  localparam int SEC   = 20;
  localparam int CENTI = 4;
  localparam int LIMIT = 100000;  // one simulated hour is 72000 clocks

  logic                                core_clk, reset, thermalTrip, startInhibited;
  logic                                startsClearReq, passwordOk, tripOutputRelay;
  logic                                presetHoursLoad, presetBrkLoad, nvRestore;
  logic [15:0]                         baseCurrent, ratedCurrent, thermalPct, remainMinIn;
  logic [15:0]                         waitMinIn, inhibitMinIn, presetHours;
  logic [7:0]                          startsLeftIn;
  diag_counters_pkg::phase_current_t   phaseCurrent;
  diag_counters_pkg::breaker_totals_t  presetBrk, brk_q;
  diag_counters_pkg::nv_image_t        nvRestoreImage;
  logic [15:0]                         runHours_q, thermalUsed_q, thermalSaved_q, remainMin_q;
  logic [15:0]                         waitMin_q, inhibitMin_q, startDur_q, startPeak_q;
  logic [7:0]                          startsLeft_q;
  logic                                thermalSeedLoad_q, startsClear_q, nvSaveHours_q;
  logic                                nvSaveThermal_q, nvSaveStart_q, nvSaveBreaker_q, seen;
  int                                  err_total, total_checks, cyc, expOps, expTot, n;
  int                                  hoursPulses;
  int                                  expBand[5];
  row_t                                rows[6] = '{'{16'h05dc, 0}, '{16'h07d0, 1},
    '{16'h1388, 2}, '{16'h270f, 2}, '{16'h2710, 3}, '{16'h9c40, 4}};

  machine_switchgear_diag_counters #(.SEC_CYCLES(SEC), .CENTI_CYCLES(CENTI))
    machine_switchgear_diag_counters_inst (.*);

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // periodic hour saves seen; the run is far shorter than four hours
  always @(posedge core_clk) begin
    if (nvSaveHours_q === 1'b1) hoursPulses++;
  end

  // a hang counts as a mismatch and still reaches the verdict
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chkbit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t flag %s got %b want %b", $time, what, got, exp);
    end
  endtask

  function automatic int sat(input int v);
    return (v > 65535) ? 65535 : v;
  endfunction

  // one breaker operation; expectation follows the band and kA squared math
  task automatic trip(input logic [15:0] cur, input int ph, input int band);
    int k;
    k = int'((longint'(cur) * cur) / 1000000);
    phaseCurrent = 48'(cur) << (16 * ph);
    tick(2);
    tripOutputRelay = 1'b1;
    tick(1);
    expOps = sat(expOps + 1);
    expTot = sat(expTot + k);
    expBand[band] = sat(expBand[band] + k);
    chkbit(nvSaveBreaker_q, 1'b1, "brk save");
    chk16(brk_q.ops, 16'(expOps), "ops");
    chk16(brk_q.total, 16'(expTot), "total");
    chk16(brk_q.band[band], 16'(expBand[band]), "band");
    tick(2);
    chk16(brk_q.ops, 16'(expOps), "ops held");
    tripOutputRelay = 1'b0;
    tick(1);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {thermalTrip, startInhibited, startsClearReq, passwordOk, tripOutputRelay} = '0;
    {presetHoursLoad, presetBrkLoad, nvRestore} = '0;
    baseCurrent = 16'hea60;  // high base keeps the start period quiet
    ratedCurrent = 16'h03e8;
    {thermalPct, remainMinIn, waitMinIn, presetHours} = '0;
    inhibitMinIn = 16'h0005;  // nonzero so a saved thermal value survives
    startsLeftIn = 8'h00;
    phaseCurrent = '0;
    presetBrk = '{band: {5{16'h0010}}, total: 16'h0100, ops: 16'h0003};
    nvRestoreImage = '0;
    tick(20);
    chk16(runHours_q, 16'h0000, "hours in reset");
    chk16(brk_q.ops, 16'h0000, "ops in reset");
    reset = 1'b0;
    // breaker preset, then the band rows
    presetBrkLoad = 1'b1;
    tick(1);
    presetBrkLoad = 1'b0;
    chk16(brk_q.total, 16'h0100, "brk preset");
    chk16(brk_q.ops, 16'h0003, "ops preset");
    expOps = 3;
    expTot = 256;
    foreach (expBand[i]) expBand[i] = 16;
    for (int i = 0; i < 6; i++) trip(rows[i].cur, i % 3, rows[i].band);
    // thermal save on trip, trip beats clear, then clear
    thermalPct = 16'h0055;
    thermalTrip = 1'b1;
    tick(1);
    chk16(thermalSaved_q, 16'h005f, "thermal save");
    chkbit(nvSaveThermal_q, 1'b1, "thermal nv");
    thermalPct = 16'h0014;
    inhibitMinIn = 16'h0000;
    tick(1);
    chk16(thermalSaved_q, 16'h001e, "trip over clear");
    thermalTrip = 1'b0;
    tick(1);
    chk16(thermalSaved_q, 16'h0000, "thermal clear");
    chkbit(nvSaveThermal_q, 1'b1, "clear nv");
    // readouts clamp at their ranges after a second tick
    remainMinIn = 16'h03e8;
    waitMinIn = 16'h03e6;
    inhibitMinIn = 16'h0190;
    startInhibited = 1'b1;
    startsLeftIn = 8'h46;
    tick(2 * SEC + 2);
    chk16(thermalUsed_q, 16'h0014, "thermal pct");
    chk16(remainMin_q, 16'h03e7, "remain clamp");
    chk16(waitMin_q, 16'h03e6, "wait");
    chk16(inhibitMin_q, 16'h0168, "inhibit clamp");
    chk16({8'h00, startsLeft_q}, 16'h003c, "starts clamp");
    // clear without password is ignored, with password accepted
    startsClearReq = 1'b1;
    tick(1);
    chkbit(startsClear_q, 1'b0, "clear no pass");
    passwordOk = 1'b1;
    tick(1);
    chkbit(startsClear_q, 1'b1, "clear pass");
    chk16({8'h00, startsLeft_q}, 16'h0000, "starts cleared");
    {startsClearReq, passwordOk, startInhibited} = '0;
    tick(SEC + 2);
    chk16(inhibitMin_q, 16'h0000, "not inhibited");
    // restore wins over a same-cycle preset and reseeds thermal
    nvRestoreImage = '{runHours: 16'h1234, thermal: 16'h0040, startDur: 16'h0007,
      startPeak: 16'h0099, brk: '{band: {16'h0005, 16'h0004, 16'h0100, 16'h0002,
      16'h0001}, total: 16'hfff0, ops: 16'hffff}};
    presetHours = 16'h4321;
    {nvRestore, presetHoursLoad} = 2'b11;
    tick(1);
    {nvRestore, presetHoursLoad} = 2'b00;
    chkbit(thermalSeedLoad_q, 1'b1, "seed load");
    chk16(runHours_q, 16'h1234, "restore hours");
    chk16(thermalSaved_q, 16'h0040, "restore thermal");
    chk16(startPeak_q, 16'h0099, "restore peak");
    tick(1);
    chkbit(thermalSeedLoad_q, 1'b0, "seed pulse");
    expOps = 65535;
    expTot = 65520;
    expBand = '{1, 2, 256, 4, 5};
    trip(16'h1388, 1, 2);
    // start period: any phase above 1.2 base, peak tracked
    baseCurrent = 16'h03e8;
    phaseCurrent = {16'h0000, 16'h0514, 16'h04e2};
    tick(2);
    phaseCurrent = {16'h0578, 16'h0514, 16'h04e2};
    tick(10 * CENTI - 2);
    phaseCurrent = {16'h0000, 16'h0000, 16'h0064};
    seen = 1'b0;
    for (n = 0; n < 4 && !seen; n++) begin
      tick(1);
      seen = (nvSaveStart_q === 1'b1);
    end
    chkbit(seen, 1'b1, "start save");
    chk16(startPeak_q, 16'h0578, "start peak");
    chkbit(startDur_q >= 16'h0009 && startDur_q <= 16'h000b, 1'b1, "start dur");
    // hours: preset near the top, then one running hour
    presetHours = 16'hfffe;
    presetHoursLoad = 1'b1;
    tick(1);
    presetHoursLoad = 1'b0;
    chk16(runHours_q, 16'hfffe, "hours preset");
    phaseCurrent = {16'h0000, 16'h0000, 16'h044c};
    for (n = 0; n < 3600 * SEC + 50 && runHours_q === 16'hfffe; n++) tick(1);
    chk16(runHours_q, 16'hffff, "hour count");
    tick(2);
    chk16(runHours_q, 16'hffff, "hours held");
    chkbit(hoursPulses == 0, 1'b1, "no early hour save");
    end_of_test();
  end

endmodule // machine_switchgear_diag_counters_test
